/* verilog/ftac_regs.svh */
// register offsets, field positions and timing counts of the frame trigger block
// How it works
// (R1) Grab request without free run or trigger method acquires exactly one frame.
// (R2) Free run with method 0 acquires frames back to back while grab stays set.
// (R3) With a trigger method selected, acquisition waits for the selected trigger.
// (R4) Status bit 5 reads the present serial-link trigger level.
// (R5) No free run: 0 next frame, 1 application trigger, 2 serial trigger, one frame.
// (R6) Free run: 0 free_run_acquire, 1 frame per optocoupler edge, 2 per serial edge.
// (R7) Free run: 5 or 6 wait for one trigger, then acquire continuously.
// (R8) Software programs only listed free-run and method combinations; others undefined.
// (R9) Pin select bit picks trigger pin a (0, default) or pin b (1).
// (R10) Override lets exposure assert during frame valid; primed waits for exposure end.
// (R11) Interrupt source bit picks optocoupler instead of camera frame valid.
// (R12) Interrupt enable raises frame-valid interrupt on falling edge of its source.
// (R13) Writing one to command bit 4 clears the pending frame-valid interrupt.
// (R14) A 24-bit preloaded period counter counts down in microseconds.
// (R15) Software preloads n minus one for a period of n microseconds.
// (R16) The period value can replace frame-valid duration, stretching or shortening it.
// (R17) Utility 3 bits 7 and 6 enable the counter and the frame-valid adjust.
// (R18) Hardware exposure bit drives exposure from the user trigger chosen by method.
// (R19) Period bytes are little-endian, lowest offset holds the low byte.
// (R20) Trigger inputs are synchronised and edge-detected so each event counts once.
`ifndef FTAC_REGS_SVH
`define FTAC_REGS_SVH

`define FTAC_OFS_COMMAND      8'h00
`define FTAC_OFS_STATUS       8'h01
`define FTAC_OFS_UTIL3        8'h05
`define FTAC_OFS_DATA_PATH    8'h06
`define FTAC_OFS_UTILITY      8'h0F
`define FTAC_OFS_UTIL2        8'h10
`define FTAC_OFS_PERIOD0      8'h14
`define FTAC_OFS_PERIOD1      8'h15
`define FTAC_OFS_PERIOD2      8'h16

`define FTAC_CMD_GRAB         1
`define FTAC_CMD_APP_TRIG     2
`define FTAC_CMD_IRQ_CLEAR    4
`define FTAC_ST_IRQ           0
`define FTAC_ST_BUSY          1
`define FTAC_ST_LINK_TRIG     5
`define FTAC_ST_PRIMED        6
`define FTAC_DP_FREE_RUN      4
`define FTAC_UT_HW_EXP        5
`define FTAC_U2_PIN_SEL       7
`define FTAC_U2_OVERRIDE      5
`define FTAC_U2_IRQ_SRC       4
`define FTAC_U2_IRQ_EN        3
`define FTAC_U3_PERIOD_EN     7
`define FTAC_U3_FV_ADJ        6

`define FTAC_M_NEXT           3'h0
`define FTAC_M_APP_OPTO       3'h1
`define FTAC_M_SERIAL         3'h2
`define FTAC_M_OPTO_RUN       3'h5
`define FTAC_M_SERIAL_RUN     3'h6

`define FTAC_CLK_FREQ_MHZ     25
`define FTAC_US_CYCLES        (`FTAC_CLK_FREQ_MHZ * 1)
`define FTAC_EXPOSURE_STROBE_TIME_US   10
`define FTAC_EXPOSURE_STROBE_CYCLES    (`FTAC_EXPOSURE_STROBE_TIME_US * `FTAC_CLK_FREQ_MHZ)

`endif

/* verilog/ftac_pkg.sv */
// types shared by the frame trigger block
package ftac_pkg;

    typedef logic [7:0] ftac_byte_type;

    typedef enum logic [2:0]
    {
        FTAC_IDLE    = 3'b000,
        FTAC_WAIT    = 3'b001,
        FTAC_EXPOSURE_STROBE  = 3'b010,
        FTAC_CAPTURE = 3'b011,
        FTAC_HOLD    = 3'b100
    } ftac_state_type;

    typedef struct packed
    {
        ftac_state_type state;
        logic           grab;
        logic           app_trig;
        logic           free_run;
        logic           hw_exp;
        logic [7:0]     util2;
        logic           period_en;
        logic           fv_adj;
        logic [23:0]    preload;
        logic [7:0]     rd_data;
        logic [2:0]     sa;
        logic [2:0]     sb;
        logic [2:0]     ss;
        logic           fv_prev;
        logic           src_prev;
        logic           irq;
        logic           exposure_strobe;
        logic [11:0]    exp_cnt;
        logic           seen_fv;
        logic           done;
        logic           start;
    } ftac_top_state_type;

    typedef struct packed
    {
        logic [4:0]  us_cnt;
        logic [23:0] cnt;
        logic        running;
    } ftac_cnt_state_type;

endpackage

/* verilog/ftac_period_if.sv */
// link between acquisition control and the frame period counter
`timescale 1ns/1ps
interface ftac_period_if;
    logic [23:0] preload;
    logic        enable;
    logic        start;
    logic        running;

    modport ctl     (output preload, output enable, output start, input running);
    modport counter (input preload, input enable, input start, output running);
endinterface

/* verilog/ftac_period_counter.sv */
// microsecond frame period down-counter
`timescale 1ns/1ps
`include "ftac_regs.svh"
module ftac_period_counter
(
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    ftac_period_if.counter       pif
);
    import ftac_pkg::*;

    ftac_cnt_state_type s;
    ftac_cnt_state_type next_s;
    logic               tick;

    assign tick        = (s.us_cnt == 5'h00);
    assign pif.running = s.running;

    always_comb
    begin
        next_s = s;
        if (pif.start && pif.enable)
        begin
            next_s.cnt     = pif.preload;
            next_s.running = 1'b1;
            next_s.us_cnt  = 5'(`FTAC_US_CYCLES - 1);
        end
        else if (s.running)
        begin
            if (tick)
            begin
                next_s.us_cnt = 5'(`FTAC_US_CYCLES - 1);
                if (s.cnt == 24'h000000)
                    next_s.running = 1'b0; // see (R14)
                else
                    next_s.cnt = s.cnt - 24'h000001; // see (R14)
            end
            else
                next_s.us_cnt = s.us_cnt - 5'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    AST_COUNT_DOWN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see (R14)
        s.running && tick && s.cnt != 24'h000000 && !pif.start |=> s.cnt == $past(s.cnt) - 24'h000001)
        else $error("period counter did not step down");
    AST_US_SPACING: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see (R14)
        s.running && tick && !pif.start |=> !tick [*8])
        else $error("microsecond tick spacing wrong");

endmodule

/* verilog/ftac_top.sv */
// acquisition trigger control: register port, trigger routing, frame sequencing
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "ftac_regs.svh"
module ftac_top
(
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    input  wire ftac_pkg::ftac_byte_type i_addr,
    input  wire ftac_pkg::ftac_byte_type i_wr_data,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    output ftac_pkg::ftac_byte_type o_rd_data,
    input  wire logic              i_trigger_pin_a,
    input  wire logic              i_trigger_pin_b,
    input  wire logic              i_serial_link_trigger_line,
    input  wire logic              i_frame_valid,
    output logic                   o_exposure_strobe,
    output logic                   o_capture_active,
    output logic                   o_frame_done,
    output logic                   o_frame_valid_adj,
    output logic                   o_fv_irq
);
    import ftac_pkg::*;

    logic [1:0]         rst_sync;
    logic               rst_n;
    ftac_top_state_type s;
    ftac_top_state_type next_s;
    ftac_period_if      pif ();

    logic [2:0] method;
    logic       pin_sel;
    logic       override;
    logic       opto_lvl;
    logic       opto_rise;
    logic       ser_lvl;
    logic       ser_rise;
    logic       is_serial;
    logic       user_lvl;
    logic       trig_hit;
    logic       fv_eff;
    logic       fv_fall;
    logic       irq_src;
    logic       primed;
    logic       per_trig;
    logic       cmd_wr;

    // two-stage release keeps reset deassertion clean against the clock
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    ftac_period_counter u_period
    (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .pif     (pif.counter)
    );

    assign pif.preload = s.preload;
    assign pif.enable  = s.period_en; // see (R17)
    assign pif.start   = s.start;

    assign method    = s.util2[2:0];
    assign pin_sel   = s.util2[`FTAC_U2_PIN_SEL];
    assign override  = s.util2[`FTAC_U2_OVERRIDE];
    // sa/sb/ss[1] are synchronised levels, [2] the previous level for edges
    assign opto_lvl  = pin_sel ? s.sb[1] : s.sa[1]; // see (R9)
    assign opto_rise = pin_sel ? (s.sb[1] & ~s.sb[2]) : (s.sa[1] & ~s.sa[2]); // see (R20)
    assign ser_lvl   = s.ss[1];
    assign ser_rise  = s.ss[1] & ~s.ss[2]; // see (R20)
    assign is_serial = (method == `FTAC_M_SERIAL) || (method == `FTAC_M_SERIAL_RUN);
    assign user_lvl  = is_serial ? ser_lvl : opto_lvl; // see (R18)
    assign per_trig  = (method == `FTAC_M_APP_OPTO) || (method == `FTAC_M_SERIAL);
    // the counter window replaces camera frame valid when both the counter and adjust are on
    assign fv_eff    = (s.period_en && s.fv_adj) ? pif.running : i_frame_valid; // see (R16)
    assign fv_fall   = s.fv_prev & ~fv_eff;
    assign irq_src   = s.util2[`FTAC_U2_IRQ_SRC] ? opto_lvl : fv_eff; // see (R11)
    assign primed    = ((s.state == FTAC_WAIT) || (s.state == FTAC_HOLD)) &&
                       !(override && s.exposure_strobe); // see (R10)
    assign cmd_wr    = i_wr_en && (i_addr == `FTAC_OFS_COMMAND);

    always_comb
    begin
        trig_hit = 1'b0;
        if (!s.free_run)
        begin
            if (method == `FTAC_M_APP_OPTO)
                trig_hit = s.app_trig; // see (R5)
            else if (method == `FTAC_M_SERIAL)
                trig_hit = ser_rise; // see (R5)
        end
        else
        begin
            if (method == `FTAC_M_APP_OPTO || method == `FTAC_M_OPTO_RUN)
                trig_hit = opto_rise; // see (R6) (R7)
            else if (method == `FTAC_M_SERIAL || method == `FTAC_M_SERIAL_RUN)
                trig_hit = ser_rise; // see (R6) (R7)
        end
    end

    always_comb
    begin
        next_s          = s;
        next_s.rd_data  = 8'h00;
        next_s.app_trig = 1'b0;
        next_s.done     = 1'b0;
        next_s.start    = 1'b0;
        next_s.sa       = {s.sa[1:0], i_trigger_pin_a};
        next_s.sb       = {s.sb[1:0], i_trigger_pin_b};
        next_s.ss       = {s.ss[1:0], i_serial_link_trigger_line};
        next_s.fv_prev  = fv_eff;
        next_s.src_prev = irq_src;

        // exposure from the user trigger is held off during frame valid unless overridden
        if (s.hw_exp)
            next_s.exposure_strobe = user_lvl & (override | ~i_frame_valid); // see (R18) (R10)

        case (s.state)
            FTAC_IDLE:
            begin
                if (s.grab)
                begin
                    if (method != `FTAC_M_NEXT)
                        next_s.state = FTAC_WAIT; // see (R3)
                    else
                    begin
                        next_s.state   = FTAC_EXPOSURE_STROBE; // see (R1) (R2)
                        next_s.exp_cnt = 12'(`FTAC_EXPOSURE_STROBE_CYCLES);
                    end
                end
            end
            FTAC_WAIT:
            begin
                if (!s.grab)
                    next_s.state = FTAC_IDLE;
                else if (trig_hit)
                begin
                    next_s.state   = FTAC_EXPOSURE_STROBE; // see (R3)
                    next_s.exp_cnt = 12'(`FTAC_EXPOSURE_STROBE_CYCLES);
                end
            end
            FTAC_EXPOSURE_STROBE:
            begin
                if (s.hw_exp || s.exp_cnt == 12'h000)
                begin
                    next_s.state   = FTAC_CAPTURE;
                    next_s.start   = 1'b1;
                    next_s.seen_fv = 1'b0;
                    if (!s.hw_exp)
                        next_s.exposure_strobe = 1'b0;
                end
                else if (!override && i_frame_valid)
                begin
                    // a frame still in transfer: restart the exposure afterwards
                    next_s.exp_cnt = 12'(`FTAC_EXPOSURE_STROBE_CYCLES); // see (R10)
                    next_s.exposure_strobe  = 1'b0;
                end
                else
                begin
                    next_s.exp_cnt = s.exp_cnt - 12'h001;
                    next_s.exposure_strobe  = 1'b1;
                end
            end
            FTAC_CAPTURE:
            begin
                if (fv_eff)
                    next_s.seen_fv = 1'b1;
                if (fv_fall && s.seen_fv)
                begin
                    next_s.done = 1'b1;
                    if (!s.free_run)
                    begin
                        next_s.state = FTAC_IDLE; // see (R1) (R5)
                        next_s.grab  = 1'b0;
                    end
                    else if (!s.grab)
                        next_s.state = FTAC_IDLE;
                    else if (per_trig)
                        next_s.state = FTAC_WAIT; // see (R6)
                    else if (s.period_en)
                        next_s.state = FTAC_HOLD; // see (R17)
                    else
                    begin
                        next_s.state   = FTAC_EXPOSURE_STROBE; // see (R2) (R7)
                        next_s.exp_cnt = 12'(`FTAC_EXPOSURE_STROBE_CYCLES);
                    end
                end
            end
            FTAC_HOLD:
            begin
                // frame rate pacing: next frame only once the period has run out
                if (!s.grab)
                    next_s.state = FTAC_IDLE;
                else if (!pif.running)
                begin
                    next_s.state   = FTAC_EXPOSURE_STROBE; // see (R14)
                    next_s.exp_cnt = 12'(`FTAC_EXPOSURE_STROBE_CYCLES);
                end
            end
            default:
                next_s.state = FTAC_IDLE;
        endcase

        // a clear write loses against an edge arriving in the same cycle
        if (cmd_wr && i_wr_data[`FTAC_CMD_IRQ_CLEAR])
            next_s.irq = 1'b0; // see (R13)
        if (s.util2[`FTAC_U2_IRQ_EN] && s.src_prev && !irq_src)
            next_s.irq = 1'b1; // see (R12) (R11)

        if (i_wr_en)
        begin
            if (i_addr == `FTAC_OFS_COMMAND)
            begin
                next_s.grab     = i_wr_data[`FTAC_CMD_GRAB];
                next_s.app_trig = i_wr_data[`FTAC_CMD_APP_TRIG];
            end
            else if (i_addr == `FTAC_OFS_UTIL3)
            begin
                next_s.period_en = i_wr_data[`FTAC_U3_PERIOD_EN]; // see (R17)
                next_s.fv_adj    = i_wr_data[`FTAC_U3_FV_ADJ]; // see (R17)
            end
            else if (i_addr == `FTAC_OFS_DATA_PATH)
                next_s.free_run = i_wr_data[`FTAC_DP_FREE_RUN];
            else if (i_addr == `FTAC_OFS_UTILITY)
                next_s.hw_exp = i_wr_data[`FTAC_UT_HW_EXP];
            else if (i_addr == `FTAC_OFS_UTIL2)
                next_s.util2 = i_wr_data;
            else if (i_addr == `FTAC_OFS_PERIOD0)
                next_s.preload[7:0] = i_wr_data; // see (R19)
            else if (i_addr == `FTAC_OFS_PERIOD1)
                next_s.preload[15:8] = i_wr_data; // see (R19)
            else if (i_addr == `FTAC_OFS_PERIOD2)
                next_s.preload[23:16] = i_wr_data; // see (R19)
        end

        if (i_rd_en)
        begin
            if (i_addr == `FTAC_OFS_COMMAND)
                next_s.rd_data[`FTAC_CMD_GRAB] = s.grab;
            else if (i_addr == `FTAC_OFS_STATUS)
            begin
                next_s.rd_data[`FTAC_ST_IRQ]       = s.irq;
                next_s.rd_data[`FTAC_ST_BUSY]      = (s.state != FTAC_IDLE);
                next_s.rd_data[`FTAC_ST_LINK_TRIG] = ser_lvl; // see (R4)
                next_s.rd_data[`FTAC_ST_PRIMED]    = primed;
            end
            else if (i_addr == `FTAC_OFS_UTIL3)
            begin
                next_s.rd_data[`FTAC_U3_PERIOD_EN] = s.period_en;
                next_s.rd_data[`FTAC_U3_FV_ADJ]    = s.fv_adj;
            end
            else if (i_addr == `FTAC_OFS_DATA_PATH)
                next_s.rd_data[`FTAC_DP_FREE_RUN] = s.free_run;
            else if (i_addr == `FTAC_OFS_UTILITY)
                next_s.rd_data[`FTAC_UT_HW_EXP] = s.hw_exp;
            else if (i_addr == `FTAC_OFS_UTIL2)
                next_s.rd_data = s.util2;
            else if (i_addr == `FTAC_OFS_PERIOD0)
                next_s.rd_data = s.preload[7:0];
            else if (i_addr == `FTAC_OFS_PERIOD1)
                next_s.rd_data = s.preload[15:8];
            else if (i_addr == `FTAC_OFS_PERIOD2)
                next_s.rd_data = s.preload[23:16];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign o_rd_data         = s.rd_data;
    assign o_exposure_strobe = s.exposure_strobe;
    assign o_capture_active  = (s.state == FTAC_CAPTURE);
    assign o_frame_done      = s.done;
    assign o_frame_valid_adj = s.fv_prev;
    assign o_fv_irq          = s.irq;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    AST_SINGLE_ENDS: assert property ( // see (R1)
        s.state == FTAC_CAPTURE && fv_fall && s.seen_fv && !s.free_run && !cmd_wr
        |=> s.state == FTAC_IDLE && !s.grab ##1 !o_capture_active)
        else $error("single grab did not finish after one frame");
    AST_RUN_RESTART: assert property ( // see (R2)
        s.state == FTAC_CAPTURE && fv_fall && s.seen_fv && s.free_run && s.grab &&
        method == `FTAC_M_NEXT && !s.period_en |=> s.state == FTAC_EXPOSURE_STROBE)
        else $error("free run did not start the next frame");
    AST_WAIT_HOLDS: assert property ( // see (R3)
        s.state == FTAC_WAIT && s.grab && !trig_hit && !cmd_wr |=> s.state == FTAC_WAIT)
        else $error("acquisition left wait without trigger");
    AST_LINK_LEVEL: assert property ( // see (R4)
        i_rd_en && i_addr == `FTAC_OFS_STATUS |=> o_rd_data[`FTAC_ST_LINK_TRIG] == $past(s.ss[1]))
        else $error("status link trigger bit wrong");
    AST_PER_TRIGGER: assert property ( // see (R6)
        s.state == FTAC_CAPTURE && fv_fall && s.seen_fv && s.free_run && s.grab && per_trig
        |=> s.state == FTAC_WAIT)
        else $error("per trigger mode did not rearm");
    AST_ONE_TRIGGER_RUN: assert property ( // see (R7)
        s.state == FTAC_CAPTURE && fv_fall && s.seen_fv && s.free_run && s.grab && !s.period_en &&
        (method == `FTAC_M_OPTO_RUN || method == `FTAC_M_SERIAL_RUN) |=> s.state == FTAC_EXPOSURE_STROBE)
        else $error("run after trigger did not continue");
    AST_EXPOSURE_STROBE_GATED: assert property ( // see (R10)
        $rose(o_exposure_strobe) && !s.hw_exp && !override |-> !$past(i_frame_valid))
        else $error("exposure rose during frame valid without override");
    AST_EXPOSURE_STROBE_LEN: assert property ( // see (R10)
        $rose(o_exposure_strobe) && !s.hw_exp && !override |-> o_exposure_strobe [*8])
        else $error("internal exposure pulse too short");
    AST_IRQ_SET: assert property ( // see (R12)
        s.util2[`FTAC_U2_IRQ_EN] && s.src_prev && !irq_src |=> o_fv_irq ##1 o_fv_irq || $past(cmd_wr))
        else $error("frame valid interrupt not raised");
    AST_IRQ_CLEAR: assert property ( // see (R13)
        cmd_wr && i_wr_data[`FTAC_CMD_IRQ_CLEAR] && !(s.src_prev && !irq_src) |=> !o_fv_irq)
        else $error("interrupt clear ignored");

    COV_SINGLE: cover property (s.state == FTAC_CAPTURE && !s.free_run ##[1:1000] o_frame_done);
    COV_WAIT_TRIG: cover property (s.state == FTAC_WAIT ##1 s.state == FTAC_EXPOSURE_STROBE);
    COV_HOLD: cover property (s.state == FTAC_HOLD ##1 s.state == FTAC_EXPOSURE_STROBE);
    COV_IRQ: cover property ($rose(o_fv_irq));

endmodule

/* tb/ftac_cam_model.sv */
// camera model: one frame valid burst after each exposure pulse
`timescale 1ns/1ps
module ftac_cam_model
(
    input  wire logic i_clk,
    input  wire logic i_exposure_strobe,
    output logic      o_frame_valid
);
    logic [7:0] cnt   = 8'h00;
    logic       exp_d = 1'b0;

    initial o_frame_valid = 1'b0;

    // readout starts a few cycles after exposure ends, as a real sensor would
    always @(posedge i_clk)
    begin
        exp_d <= i_exposure_strobe;
        if (exp_d && !i_exposure_strobe)
            cnt <= 8'h1E;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
        o_frame_valid <= (cnt != 8'h00) && (cnt <= 8'h14);
    end
endmodule

/* tb/test_frame_trigger_acquire_ctrl.sv */
// self-checking bench of the acquisition trigger block
`timescale 1ns/1ps
`include "ftac_regs.svh"
module test_frame_trigger_acquire_ctrl;
    import ftac_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} ftac_row_type;

    logic          i_clk, i_arst_n, i_wr_en, i_rd_en, i_trig_b, i_slt, fv, exp_s;
    logic          pin_a, cap, done, fv_adj, irq, exp_d;
    ftac_byte_type i_addr, i_wr_data, rd_data, d;
    int            num_errors, check_count, exp_rises, n0, fv_cycles;
    ftac_row_type  rows [9] = '{
        '{8'h10, 8'hA5, 8'hA5}, '{8'h06, 8'hFF, 8'h10}, '{8'h0F, 8'hFF, 8'h20},
        '{8'h05, 8'hFF, 8'hC0}, '{8'h14, 8'h0E, 8'h0E}, '{8'h15, 8'h27, 8'h27},
        '{8'h16, 8'h00, 8'h00}, '{8'h30, 8'hFF, 8'h00}, '{8'h10, 8'hBE, 8'hBE}};

    ftac_top u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(rd_data), .i_trigger_pin_a(pin_a),
        .i_trigger_pin_b(i_trig_b), .i_serial_link_trigger_line(i_slt), .i_frame_valid(fv),
        .o_exposure_strobe(exp_s), .o_capture_active(cap), .o_frame_done(done),
        .o_frame_valid_adj(fv_adj), .o_fv_irq(irq));
    ftac_cam_model u_cam (.i_clk(i_clk), .i_exposure_strobe(exp_s), .o_frame_valid(fv));

    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        exp_d <= exp_s;
        if (exp_s === 1'b1 && exp_d === 1'b0)
            exp_rises <= exp_rises + 1;
        if (fv_adj === 1'b1)
            fv_cycles <= fv_cycles + 1;
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= w;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge i_clk);
            #1;
            if (done === 1'b1)
                return;
        end
        $display("unexpected frame_done expected 1 seen timeout");
        num_errors++;
        summarize();
    endtask

    task automatic do_reset();
        i_arst_n <= 1'b0;
        repeat (20) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask

    initial
    begin
        {i_wr_en, i_rd_en, i_trig_b, i_slt, pin_a, exp_d} = '0;
        {i_addr, i_wr_data, num_errors, check_count, exp_rises, fv_cycles} = '0;
        i_arst_n = 1'b0;
        do_reset();
        foreach (rows[k])
        begin
            wr(rows[k].a, rows[k].w);
            rd(rows[k].a);
            chk("reg", rows[k].e, d);
        end
        do_reset();
        rd(`FTAC_OFS_UTIL2);
        chk("util2 reset", 8'h00, d);
        wr(`FTAC_OFS_COMMAND, 8'h02);
        wait_done();
        repeat (600) @(posedge i_clk);
        chk("single frames", 8'd1, 8'(exp_rises));
        rd(`FTAC_OFS_COMMAND);
        chk("grab after frame", 8'h00, d);
        i_slt <= 1'b1;
        repeat (5) @(posedge i_clk);
        rd(`FTAC_OFS_STATUS);
        chk("link level", 8'h01, {7'h00, d[5]});
        i_slt <= 1'b0;
        // application trigger must be needed before anything exposes
        wr(`FTAC_OFS_UTIL2, 8'h01);
        wr(`FTAC_OFS_COMMAND, 8'h02);
        repeat (100) @(posedge i_clk);
        chk("held off", 8'd1, 8'(exp_rises));
        wr(`FTAC_OFS_COMMAND, 8'h06);
        wait_done();
        chk("app trig frame", 8'd2, 8'(exp_rises));
        wr(`FTAC_OFS_UTIL2, 8'h08);
        wr(`FTAC_OFS_COMMAND, 8'h02);
        wait_done();
        repeat (2) @(posedge i_clk);
        chk("irq set", 8'h01, {7'h00, irq});
        wr(`FTAC_OFS_COMMAND, 8'h10);
        repeat (2) @(posedge i_clk);
        chk("irq clear", 8'h00, {7'h00, irq});
        // free run per serial edge; only listed combinations are used
        wr(`FTAC_OFS_DATA_PATH, 8'h10);
        wr(`FTAC_OFS_UTIL2, 8'h02);
        wr(`FTAC_OFS_COMMAND, 8'h02);
        n0 = exp_rises;
        repeat (100) @(posedge i_clk);
        chk("no serial edge", 8'(n0), 8'(exp_rises));
        i_slt <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_slt <= 1'b0;
        wait_done();
        repeat (600) @(posedge i_clk);
        chk("one per edge", 8'(n0 + 1), 8'(exp_rises));
        // method 0 never leaves wait, so regrab after changing it
        wr(`FTAC_OFS_COMMAND, 8'h00);
        wr(`FTAC_OFS_UTIL2, 8'h00);
        wr(`FTAC_OFS_COMMAND, 8'h02);
        wait_done();
        wait_done();
        wr(`FTAC_OFS_COMMAND, 8'h00);
        chk("free_run_acquire", 8'h01, 8'(exp_rises >= n0 + 3));
        repeat (900) @(posedge i_clk);
        rd(`FTAC_OFS_STATUS);
        chk("stopped", 8'h00, {7'h00, d[1]});
        // pin b selected, run after one edge, irq from the pin
        wr(`FTAC_OFS_UTIL2, 8'h9D);
        wr(`FTAC_OFS_COMMAND, 8'h02);
        pin_a <= 1'b1;
        repeat (10) @(posedge i_clk);
        pin_a <= 1'b0;
        repeat (20) @(posedge i_clk);
        chk("pin a ignored", 8'h00, {7'h00, exp_s});
        n0 = exp_rises;
        i_trig_b <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_trig_b <= 1'b0;
        wait_done();
        chk("opto irq", 8'h01, {7'h00, irq});
        wr(`FTAC_OFS_COMMAND, 8'h12);
        wait_done();
        wait_done();
        chk("no fv irq", 8'h00, {7'h00, irq});
        chk("run after trigger", 8'h01, 8'(exp_rises >= n0 + 3));
        wr(`FTAC_OFS_COMMAND, 8'h00);
        repeat (900) @(posedge i_clk);
        wr(`FTAC_OFS_UTIL2, 8'h02);
        wr(`FTAC_OFS_DATA_PATH, 8'h00);
        wr(`FTAC_OFS_UTILITY, 8'h20);
        wr(`FTAC_OFS_COMMAND, 8'h02);
        i_slt <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk("hw exposure", 8'h01, {7'h00, exp_s});
        chk("capturing", 8'h01, {7'h00, cap});
        i_slt <= 1'b0;
        wait_done();
        // counter window stands for frame valid: (preload + 1) microseconds
        wr(`FTAC_OFS_UTILITY, 8'h00);
        wr(`FTAC_OFS_UTIL2, 8'h00);
        wr(`FTAC_OFS_UTIL3, 8'hC0);
        wr(`FTAC_OFS_PERIOD0, 8'h03);
        n0 = fv_cycles;
        wr(`FTAC_OFS_COMMAND, 8'h02);
        wait_done();
        repeat (2) @(posedge i_clk);
        chk("fv window", 8'(4 * `FTAC_US_CYCLES), 8'(fv_cycles - n0));
        summarize();
    end
endmodule
